// [trace_qual_defines.vh]
// Constants for the bus trace qualifier: trace modes and sizes.
// Assumes inclusion by bare name from the design files.
`ifndef TRACE_QUAL_DEFINES_VH
`define TRACE_QUAL_DEFINES_VH

// ----------------------------------------
// Trace modes of the active event group
// ----------------------------------------
`define MODE_ALL 2'h0
`define MODE_QUAL 2'h1
`define MODE_TOGGLE 2'h2

// ----------------------------------------
// Default sizes
// ----------------------------------------
`define CYCLE_W 40
`define FIFO_DEPTH 32
`define FIFO_AW 5
`define TRACE_DEPTH 1024
`define TRACE_AW 10

`endif

// [trace_fifo.v]
// FIFO of bus cycle words between the qualifier and trace memory.
// Assumes one clock; synchronous active-high reset.
`timescale 1ns/1ps
module trace_fifo #(
	parameter WIDTH = 40,
	parameter DEPTH = 32,
	parameter AW = 5
) (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// Drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem_r [0:DEPTH-1];
	reg [AW-1:0] wr_r;
	reg [AW-1:0] rd_r;
	reg [AW:0] cnt_r;
	wire push;
	wire pop;

	assign in_ready = (cnt_r != DEPTH[AW:0]);
	assign out_valid = (cnt_r != {(AW+1){1'b0}});
	assign out_data = mem_r[rd_r];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always @(posedge clk) begin
		if (push)
			mem_r[wr_r] <= in_data;
	end

	always @(posedge clk) begin
		if (rst) begin
			wr_r <= {AW{1'b0}};
			rd_r <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_r <= (wr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
					wr_r + 1'b1;
			if (pop)
				rd_r <= (rd_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
					rd_r + 1'b1;
			if (push & ~pop)
				cnt_r <= cnt_r + 1'b1;
			else if (pop & ~push)
				cnt_r <= cnt_r - 1'b1;
		end
	end
endmodule // trace_fifo

// [trace_mem_writer.v]
// Writes drained FIFO words into trace memory, one entry each.
// Assumes trace memory accepts a write on every cycle that mem_we is high.
`timescale 1ns/1ps
module trace_mem_writer #(
	parameter WIDTH = 40,
	parameter AW = 10
) (
	// Clock and reset
	input wire clk,
	input wire rst,
	// From FIFO
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// Memory stall
	input wire mem_busy,
	// Trace memory write port
	output reg mem_we,
	output reg [AW-1:0] mem_addr,
	output reg [WIDTH-1:0] mem_data,
	output reg [AW-1:0] wr_ptr
);
	assign in_ready = ~mem_busy;

	always @(posedge clk) begin
		if (rst) begin
			mem_we <= 1'b0;
			mem_addr <= {AW{1'b0}};
			mem_data <= {WIDTH{1'b0}};
			wr_ptr <= {AW{1'b0}};
		end else begin
			mem_we <= in_valid & ~mem_busy;
			if (in_valid & ~mem_busy) begin
				mem_addr <= wr_ptr; // [RL8]
				mem_data <= in_data;
				wr_ptr <= wr_ptr + 1'b1; // [RL8]
			end
		end
	end
endmodule // trace_mem_writer

// [bus_trace_qualifier.v]
// Bus trace qualifier: chooses which target bus cycles go to trace memory.
// Assumes one strobe per completed target bus cycle, synchronous to clk.
//
// What the document requires of this block
// RL1: Cycle meeting a qualify statement's conditions is written into trace. Code drops it on a restart edge or when the FIFO is full.
// RL2: With neither qualify nor toggle armed, every bus cycle is recorded. Code loses a cycle on a restart edge or when the FIFO is full.
// RL3: With qualify armed, only qualified cycles are recorded, others dropped. Code ignores qualify and loads the toggle state when toggle is also armed.
// RL4: With toggle armed, trace starts off; on after toggle until next.
// RL5: Group change sets trace state from the new group only.
// RL6: Run start sets initial trace state from the armed actions.
// RL7: Each toggle event inverts the trace-enable state.
// RL8: Each recorded cycle takes one entry; write pointer advances by one.
`timescale 1ns/1ps
`include "trace_qual_defines.vh"
module bus_trace_qualifier #(
	parameter WIDTH = `CYCLE_W,
	parameter DEPTH = `FIFO_DEPTH,
	parameter FAW = `FIFO_AW,
	parameter TAW = `TRACE_AW
) (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Run control and event group
	input wire run_start,
	input wire group_change,
	input wire trace_qualify_action,
	input wire trace_toggle_action,
	// Event monitor results for this bus cycle
	input wire qualify_hit,
	input wire toggle_hit,
	// Target bus cycle
	input wire cycle_valid,
	input wire [WIDTH-1:0] cycle_data,
	// Trace memory
	input wire mem_busy,
	output wire mem_we,
	output wire [TAW-1:0] mem_addr,
	output wire [WIDTH-1:0] mem_data,
	output wire [TAW-1:0] trace_wr_ptr,
	// Status
	output reg trace_on_r,
	output reg cycle_dropped_r,
	output reg [1:0] mode_r
);
	// ----------------------------------------
	// Trace states
	// ----------------------------------------
	// One flop per state: the record decision is one gate per state,
	// and a stray code falls back to the safe choice of tracing all.
	localparam [3:0] ST_ALL = 4'h1;
	localparam [3:0] ST_QUAL = 4'h2;
	localparam [3:0] ST_TOFF = 4'h4;
	localparam [3:0] ST_TON = 4'h8;

	reg [3:0] state_r;
	reg [3:0] state_nxt;
	reg [3:0] load_state;
	reg [1:0] mode_nxt;
	reg trace_on_nxt;
	reg record;
	reg drop_nxt;
	wire restart;
	wire cycle_seen;
	wire qualify_seen;
	wire toggle_seen;
	wire fifo_ready;

	// ----------------------------------------
	// Bus cycle decode
	// ----------------------------------------
	// Run entry and group change act alike: both reload the state
	assign restart = run_start | group_change; // [RL5] [RL6]
	// A cycle on a restart edge belongs to neither group and is lost
	assign cycle_seen = cycle_valid & ~restart;
	assign qualify_seen = cycle_seen & qualify_hit; // [RL1]
	assign toggle_seen = cycle_seen & toggle_hit; // [RL7]

	// ----------------------------------------
	// State loaded at run start or group change
	// ----------------------------------------
	// Toggle has priority if both are armed: the statement set is
	// ill-formed then, and toggle is the stricter of the two.
	always @* begin
		if (trace_toggle_action) begin
			load_state = ST_TOFF; // [RL4] [RL6]
		end else if (trace_qualify_action) begin
			load_state = ST_QUAL; // [RL3] [RL6]
		end else begin
			load_state = ST_ALL; // [RL2] [RL6]
		end
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	// Old group's toggle state is discarded entirely on a restart
	always @* begin
		state_nxt = state_r;
		if (restart) begin
			state_nxt = load_state; // [RL5]
		end else begin
			case (state_r)
			ST_ALL: begin
				state_nxt = ST_ALL;
			end
			ST_QUAL: begin
				state_nxt = ST_QUAL;
			end
			ST_TOFF: begin
				if (toggle_seen) begin
					state_nxt = ST_TON; // [RL7]
				end
			end
			ST_TON: begin
				if (toggle_seen) begin
					state_nxt = ST_TOFF; // [RL7]
				end
			end
			default: begin
				state_nxt = ST_ALL;
			end
			endcase
		end
	end

	// ----------------------------------------
	// Record decision
	// ----------------------------------------
	always @* begin
		record = 1'b0;
		case (state_r)
		ST_ALL: begin
			record = cycle_seen; // [RL2]
		end
		ST_QUAL: begin
			record = qualify_seen; // [RL1] [RL3]
		end
		ST_TOFF: begin
			// The cycle that turns trace on is itself traced
			record = toggle_seen; // [RL4]
		end
		ST_TON: begin
			// The cycle that turns trace off is not
			record = cycle_seen & ~toggle_hit; // [RL4]
		end
		default: begin
			record = 1'b0;
		end
		endcase
	end

	// ----------------------------------------
	// Status decode
	// ----------------------------------------
	// Decoded from the next state so the status flops change on the
	// same edge as the state flops.
	always @* begin
		case (state_nxt)
		ST_ALL: begin
			mode_nxt = `MODE_ALL;
		end
		ST_QUAL: begin
			mode_nxt = `MODE_QUAL;
		end
		ST_TOFF: begin
			mode_nxt = `MODE_TOGGLE;
		end
		ST_TON: begin
			mode_nxt = `MODE_TOGGLE;
		end
		default: begin
			mode_nxt = `MODE_ALL;
		end
		endcase
	end

	always @* begin
		case (state_nxt)
		ST_ALL: begin
			trace_on_nxt = 1'b0;
		end
		ST_QUAL: begin
			trace_on_nxt = 1'b0;
		end
		ST_TOFF: begin
			trace_on_nxt = 1'b0;
		end
		ST_TON: begin
			trace_on_nxt = 1'b1; // [RL4]
		end
		default: begin
			trace_on_nxt = 1'b0;
		end
		endcase
	end

	// Full FIFO loses the cycle: the target bus cannot be stalled
	always @* begin
		if (record & ~fifo_ready) begin
			drop_nxt = 1'b1;
		end else begin
			drop_nxt = 1'b0;
		end
	end

	// ----------------------------------------
	// State and status flops
	// ----------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			state_r <= ST_ALL;
			mode_r <= `MODE_ALL;
			trace_on_r <= 1'b0;
			cycle_dropped_r <= 1'b0;
		end else begin
			state_r <= state_nxt; // [RL5] [RL7]
			mode_r <= mode_nxt; // [RL6]
			trace_on_r <= trace_on_nxt; // [RL7]
			cycle_dropped_r <= drop_nxt;
		end
	end

	// ----------------------------------------
	// Buffer and trace memory write
	// ----------------------------------------
	wire fv;
	wire fr;
	wire [WIDTH-1:0] fd;

	trace_fifo #(
		.WIDTH(WIDTH),
		.DEPTH(DEPTH),
		.AW(FAW)
	) u_fifo (
		.clk(clk),
		.rst(rst),
		.in_valid(record),
		.in_ready(fifo_ready),
		.in_data(cycle_data),
		.out_valid(fv),
		.out_ready(fr),
		.out_data(fd)
	);

	trace_mem_writer #(
		.WIDTH(WIDTH),
		.AW(TAW)
	) u_writer (
		.clk(clk),
		.rst(rst),
		.in_valid(fv),
		.in_ready(fr),
		.in_data(fd),
		.mem_busy(mem_busy),
		.mem_we(mem_we),
		.mem_addr(mem_addr),
		.mem_data(mem_data),
		.wr_ptr(trace_wr_ptr)
	);
endmodule // bus_trace_qualifier

// [btq_checker.sv]
// Port checker for the bus trace qualifier.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
// ----
// Checker
// ----
module btq_checker #(parameter TAW = 10) (
	// Inputs
	input wire clk,
	input wire rst,
	input wire run_start,
	input wire group_change,
	input wire trace_qualify_action,
	input wire trace_toggle_action,
	input wire cycle_valid,
	input wire toggle_hit,
	// Outputs
	input wire mem_we,
	input wire [TAW-1:0] mem_addr,
	input wire [TAW-1:0] trace_wr_ptr,
	input wire trace_on_r,
	input wire [1:0] mode_r
);
	wire rs = run_start | group_change;
	wire tv = cycle_valid & toggle_hit & !rs;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_md_t; rs && trace_toggle_action |=> mode_r == 2'h2; endproperty
	a_md_t: assert property (p_md_t) else $error("mode");
	property p_md_q; rs && trace_qualify_action && !trace_toggle_action
		|=> mode_r == 2'h1; endproperty
	a_md_q: assert property (p_md_q) else $error("mode");
	property p_md_a; rs && !trace_qualify_action && !trace_toggle_action
		|=> mode_r == 2'h0; endproperty
	a_md_a: assert property (p_md_a) else $error("mode");
	property p_off; rs |=> !trace_on_r; endproperty
	a_off: assert property (p_off) else $error("state");
	property p_tg; mode_r == 2'h2 && tv |=> trace_on_r != $past(trace_on_r);
	endproperty
	a_tg: assert property (p_tg) else $error("toggle");
	property p_hold; !tv && !rs |=> $stable(trace_on_r); endproperty
	a_hold: assert property (p_hold) else $error("state");
	property p_ptr; mem_we |-> trace_wr_ptr == mem_addr + 1'b1; endproperty
	a_ptr: assert property (p_ptr) else $error("pointer");
	// Reset may clear the pointer one edge before this sample
	property p_ptrs; !mem_we && !$past(rst) |-> $stable(trace_wr_ptr);
	endproperty
	a_ptrs: assert property (p_ptrs) else $error("pointer");
endmodule // btq_checker
bind bus_trace_qualifier btq_checker #(.TAW(TAW)) chk (.clk(clk), .rst(rst),
	.run_start(run_start), .group_change(group_change),
	.trace_qualify_action(trace_qualify_action),
	.trace_toggle_action(trace_toggle_action), .cycle_valid(cycle_valid),
	.toggle_hit(toggle_hit), .mem_we(mem_we), .mem_addr(mem_addr),
	.trace_wr_ptr(trace_wr_ptr), .trace_on_r(trace_on_r), .mode_r(mode_r));

// [bus_cycle_src.sv]
// Model of the target processor's bus cycles.
// Assumes the bench hands in a fresh random word each cycle.
`timescale 1ns/1ps
// ----
// Source
// ----
module bus_cycle_src (
	// Control
	input wire clk,
	input wire en,
	input wire dense,
	input wire [31:0] rnd,
	// Bus cycle
	output reg cycle_valid,
	output reg [39:0] cycle_data,
	output reg qualify_hit,
	output reg toggle_hit
);
	initial begin
		cycle_valid = 1'b0;
		cycle_data = 40'h0;
		qualify_hit = 1'b0;
		toggle_hit = 1'b0;
	end
	// Data changes every clock, so an idle word is never stale
	always @(negedge clk) begin
		cycle_valid <= en & (dense | rnd[0]);
		cycle_data <= {rnd[7:0], rnd};
		qualify_hit <= rnd[1];
		toggle_hit <= rnd[2] & rnd[3];
	end
endmodule // bus_cycle_src

// [bus_trace_qualifier_tb_top.sv]
// Self-checking bench for the bus trace qualifier.
// Assumes the source model drives at the falling edge.
`timescale 1ns/1ps
// ----
// Bench
// ----
module bus_trace_qualifier_tb_top;
	reg clk, rst, run_start, group_change, qa, ta, en, dense, fill, mem_busy;
	reg [31:0] rnd;
	reg [1:0] m;
	reg on;
	reg [9:0] ptr;
	reg [39:0] q[$];
	reg pop, rec, psh;
	integer error_cnt, n_compared, drops, i, k, fc;
	wire cycle_valid, qualify_hit, toggle_hit, mem_we, trace_on_r, dropped;
	wire [39:0] cycle_data, mem_data;
	wire [9:0] mem_addr, trace_wr_ptr;
	wire [1:0] mode_r;
	bus_cycle_src src (.clk(clk), .en(en), .dense(dense), .rnd(rnd),
		.cycle_valid(cycle_valid), .cycle_data(cycle_data),
		.qualify_hit(qualify_hit), .toggle_hit(toggle_hit));
	bus_trace_qualifier dut (.clk(clk), .rst(rst), .run_start(run_start),
		.group_change(group_change), .trace_qualify_action(qa),
		.trace_toggle_action(ta), .qualify_hit(qualify_hit),
		.toggle_hit(toggle_hit), .cycle_valid(cycle_valid),
		.cycle_data(cycle_data), .mem_busy(mem_busy), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_data(mem_data),
		.trace_wr_ptr(trace_wr_ptr), .trace_on_r(trace_on_r),
		.cycle_dropped_r(dropped), .mode_r(mode_r));
	function [31:0] xs(input [31:0] v);
		reg [31:0] t;
		begin
			t = v ^ (v << 13);
			t = t ^ (t >> 17);
			xs = t ^ (t << 5);
		end
	endfunction
	function rec_f(input [1:0] md, input o, input qh);
		rec_f = (md == 2'h0) | (md == 2'h1 & qh) | (md == 2'h2 & o);
	endfunction
	task check(input [63:0] nm, input [63:0] seen, input [63:0] exp);
		begin
			n_compared = n_compared + 1;
			if (seen !== exp) begin
				error_cnt = error_cnt + 1;
				$display("BAD %0s exp %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task end_of_test;
		begin
			$display("compared %0d bad %0d", n_compared, error_cnt);
			if (error_cnt == 0 && n_compared > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(negedge clk) begin
		rnd <= xs(rnd);
		mem_busy <= fill | (rnd[9] & rnd[8]);
	end
	// Reference model runs on the inputs taken at the last rising edge
	always @(negedge clk) begin
		if (rst) begin
			m = 2'h0;
			on = 1'b0;
			ptr = 10'h0;
			fc = 0;
		end else begin
			// FIFO of 32: pops when not busy, refuses pushes when full
			pop = (fc != 0) && !mem_busy;
			rec = 1'b0;
			if (run_start | group_change) begin
				m = ta ? 2'h2 : {1'b0, qa};
				on = 1'b0;
			end else if (cycle_valid) begin
				if (m == 2'h2 && toggle_hit)
					on = !on;
				rec = rec_f(m, on, qualify_hit);
			end
			psh = rec && (fc != 32);
			check("we", mem_we, pop);
			if (pop) begin
				check("data", mem_data, q[0]);
				check("addr", mem_addr, ptr);
				q.delete(0);
				ptr = ptr + 10'h1;
			end
			check("ptr", trace_wr_ptr, ptr);
			check("drop", dropped, rec && !psh);
			if (psh)
				q.push_back(cycle_data);
			else if (rec)
				drops = drops + 1;
			fc = fc + psh - pop;
			check("mode", mode_r, m);
			if (m == 2'h2)
				check("on", trace_on_r, on);
		end
	end
	initial begin
		{run_start, group_change, qa, ta, en, dense, fill, mem_busy} = 8'h0;
		rst = 1'b1;
		rnd = 32'h9C4F;
		error_cnt = 0;
		n_compared = 0;
		drops = 0;
		repeat (5) @(posedge clk);
		@(negedge clk) rst <= 1'b0;
		for (i = 0; i < 9; i = i + 1) begin
			@(negedge clk);
			qa <= i[0];
			ta <= i[1] & (i < 8);
			fill <= (i == 8);
			dense <= (i == 8);
			en <= 1'b1;
			if (i[2])
				group_change <= 1'b1;
			else
				run_start <= 1'b1;
			@(negedge clk);
			run_start <= 1'b0;
			group_change <= 1'b0;
			repeat (60) @(negedge clk);
			$display("test %0d done", i);
		end
		en <= 1'b0;
		fill <= 1'b0;
		for (k = 0; k < 300 && q.size() > 0; k = k + 1)
			@(negedge clk);
		check("drop", drops > 0, 1);
		check("left", q.size(), 0);
		end_of_test;
	end
endmodule // bus_trace_qualifier_tb_top
